// ==== verilog/dma_cma_cfg.svh ====
// Constants of the per-channel memory base address block.
// Assumes an APB slave port decoding a 12-bit byte address.
//
// Overview of operation
// - Eight memory base registers, channel one at 0x014, next ones 20 bytes apart.
// - Reset clears every memory base register to zero.
// - Each channel keeps a full 32-bit memory start address, readable always, writable only while the channel is disabled.
// - With 16-bit memory width, address bit 0 is ignored; accesses half-word aligned.
// - With 32-bit memory width, address bits 1:0 are ignored; accesses word aligned.
`ifndef DMA_CMA_CFG_SVH
`define DMA_CMA_CFG_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define NUM_CHAN 8
`define ADDR_W 32
`define PADDR_W 12

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CMA_BASE 12'h014
`define CHAN_STRIDE 12'h014
`define CFG_BASE 12'h008
`define EFF_BASE 12'h100
`define EFF_STRIDE 12'h004

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EN_BIT 0
`define WIDTH_LSB 10
`define WIDTH_MSB 11

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ADDR_RESET 32'h00000000
`define WIDTH_RESET 2'h0
`define EN_RESET 1'h0

`endif

// ==== verilog/dma_cma_pkg.sv ====
// Types shared by the memory base address block and its aligner.
// Assumes the constants header is on the include path.
`include "dma_cma_cfg.svh"

package dma_cma_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [2:0] chan_t;

   typedef enum logic [1:0] {
      WIDTH_8 = 2'h0,
      WIDTH_16 = 2'h1,
      WIDTH_32 = 2'h2
   } memory_transfer_width_e;

   typedef struct packed {
      logic [1:0] memory_transfer_width;
      logic enable;
   } chan_cfg_s;

   typedef enum logic [3:0] {
      K_NONE = 4'h1,
      K_CFG = 4'h2,
      K_ADDR = 4'h4,
      K_EFF = 4'h8
   } reg_kind_e;

   typedef struct packed {
      reg_kind_e kind;
      chan_t chan;
   } reg_dec_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_RESP = 2'h2
   } apb_state_e;

endpackage

// ==== verilog/dma_cma_aligner.sv ====
// Registered alignment of one channel's memory base address.
// Assumes base and width come from registers on the same clock.
`timescale 1ns/1ps
`include "dma_cma_cfg.svh"

module dma_cma_aligner
   import dma_cma_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire addr_t base,
   input wire logic [1:0] memory_transfer_width,
   output addr_t aligned_q
);

   // -------------------------------------------------------------------------
   // Alignment
   // -------------------------------------------------------------------------
   function automatic addr_t align(input addr_t a, input logic [1:0] w);
      addr_t r;
      r = a;
      case (w)
         WIDTH_16: r[0] = 1'b0;
         WIDTH_32: r[1:0] = 2'h0;
         default: r = a;
      endcase
      return r;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aligned_q <= `ADDR_RESET;
      end else begin
         aligned_q <= align(base, memory_transfer_width);
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   a_half_align: assert property (
      @(posedge clk) disable iff (!rst_n)
      memory_transfer_width == WIDTH_16 |=> aligned_q == {$past(base[31:1]), 1'b0})
      else $error("half-word alignment wrong");

   a_word_align: assert property (
      @(posedge clk) disable iff (!rst_n)
      memory_transfer_width == WIDTH_32 |=> aligned_q == {$past(base[31:2]), 2'h0})
      else $error("word alignment wrong");

   a_byte_passes: assert property (
      @(posedge clk) disable iff (!rst_n)
      memory_transfer_width == WIDTH_8 |=> aligned_q == $past(base))
      else $error("byte width address altered");

endmodule

// ==== verilog/dma_channel_memory_address.sv ====
// APB register block holding eight channels' memory base addresses.
// Assumes an APB4 master on clk; the transfer engine reads the outputs.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "dma_cma_cfg.svh"

module dma_channel_memory_address
   import dma_cma_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output chan_cfg_s [`NUM_CHAN-1:0] chan_cfg,
   output addr_t [`NUM_CHAN-1:0] chan_mem_addr
);

   // -------------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_s_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_s_n = rst_sync_q[1];

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic reg_dec_s decode(input logic [`PADDR_W-1:0] a);
      reg_dec_s d;
      d.kind = K_NONE;
      d.chan = 3'h0;
      for (int i = 0; i < `NUM_CHAN; i++) begin
         if (a == `CMA_BASE + 12'(i) * `CHAN_STRIDE) begin
            d.kind = K_ADDR;
            d.chan = 3'(i);
         end
         if (a == `CFG_BASE + 12'(i) * `CHAN_STRIDE) begin
            d.kind = K_CFG;
            d.chan = 3'(i);
         end
         if (a == `EFF_BASE + 12'(i) * `EFF_STRIDE) begin
            d.kind = K_EFF;
            d.chan = 3'(i);
         end
      end
      return d;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wr[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] cfg_word(input chan_cfg_s c);
      logic [31:0] r;
      r = 32'h00000000;
      r[`WIDTH_MSB:`WIDTH_LSB] = c.memory_transfer_width;
      r[`EN_BIT] = c.enable;
      return r;
   endfunction

   // -------------------------------------------------------------------------
   // Decode of the current request
   // -------------------------------------------------------------------------
   reg_dec_s dec;
   logic setup;
   logic commit;
   logic wr_refused;
   logic [31:0] rd_word;
   logic [31:0] cfg_wr_word;

   assign dec = decode(paddr);
   assign setup = psel && !penable;

   apb_state_e state_q;
   logic [`NUM_CHAN-1:0][31:0] mem_base_q;
   chan_cfg_s [`NUM_CHAN-1:0] cfg_q;

   // Writes land only at the edge where the access phase meets pready
   assign commit = (state_q == ST_RESP) && psel && penable && pwrite && pready && !pslverr;

   // Config word as it stands after the byte lanes of a write
   assign cfg_wr_word = merge(cfg_word(cfg_q[dec.chan]), pwdata, pstrb);

   always_comb begin
      wr_refused = 1'b0;
      case (dec.kind)
         K_ADDR: wr_refused = cfg_q[dec.chan].enable;
         K_CFG: wr_refused = 1'b0;
         K_EFF: wr_refused = 1'b1;
         default: wr_refused = 1'b1;
      endcase
   end

   always_comb begin
      rd_word = 32'h00000000;
      case (dec.kind)
         K_ADDR: rd_word = mem_base_q[dec.chan];
         K_CFG: rd_word = cfg_word(cfg_q[dec.chan]);
         K_EFF: rd_word = chan_mem_addr[dec.chan];
         default: rd_word = 32'h00000000;
      endcase
   end

   // -------------------------------------------------------------------------
   // APB handshake
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (setup) begin
                  state_q <= ST_RESP;
               end
            end
            ST_RESP: begin
               if (psel && penable) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         pready <= 1'b0;
      end else begin
         pready <= (state_q == ST_IDLE) && setup;
      end
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         pslverr <= 1'b0;
      end else if ((state_q == ST_IDLE) && setup) begin
         pslverr <= pwrite ? wr_refused : (dec.kind == K_NONE);
      end else begin
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         prdata <= 32'h00000000;
      end else if ((state_q == ST_IDLE) && setup && !pwrite) begin
         prdata <= rd_word;
      end
   end

   // -------------------------------------------------------------------------
   // Channel registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         for (int i = 0; i < `NUM_CHAN; i++) begin
            mem_base_q[i] <= `ADDR_RESET;
         end
      end else if (commit && dec.kind == K_ADDR) begin
         mem_base_q[dec.chan] <= merge(mem_base_q[dec.chan], pwdata, pstrb);
      end
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         for (int i = 0; i < `NUM_CHAN; i++) begin
            cfg_q[i].memory_transfer_width <= `WIDTH_RESET;
            cfg_q[i].enable <= `EN_RESET;
         end
      end else if (commit && dec.kind == K_CFG) begin
         cfg_q[dec.chan].memory_transfer_width <= cfg_wr_word[`WIDTH_MSB:`WIDTH_LSB];
         cfg_q[dec.chan].enable <= cfg_wr_word[`EN_BIT];
      end
   end

   assign chan_cfg = cfg_q;

   // -------------------------------------------------------------------------
   // Alignment per channel
   // -------------------------------------------------------------------------
   for (genvar g = 0; g < `NUM_CHAN; g++) begin : g_align
      dma_cma_aligner u_align (
         .clk(clk),
         .rst_n(rst_s_n),
         .base(mem_base_q[g]),
         .memory_transfer_width(cfg_q[g].memory_transfer_width),
         .aligned_q(chan_mem_addr[g])
      );
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   sequence seq_setup_wr_addr;
      setup && pwrite && (state_q == ST_IDLE) && (dec.kind == K_ADDR);
   endsequence

   sequence seq_access_refused;
      psel && penable && pready && pslverr;
   endsequence

   sequence seq_setup_wr_eff;
      setup && pwrite && (state_q == ST_IDLE) && (dec.kind == K_EFF);
   endsequence

   a_reset_clears_base: assert property (
      @(posedge clk)
      $rose(rst_s_n) |-> (mem_base_q == '0) && (chan_mem_addr == '0))
      else $error("memory base not cleared by reset");

   a_offset_decode: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      dec.kind == K_ADDR |-> paddr == `CMA_BASE + 12'(dec.chan) * `CHAN_STRIDE)
      else $error("memory base decoded at wrong offset");

   a_base_write_kept: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      commit && dec.kind == K_ADDR && pstrb == 4'hF |=> mem_base_q[$past(dec.chan)] == $past(pwdata))
      else $error("memory base write not stored");

   a_read_full_value: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      setup && !pwrite && state_q == ST_IDLE && dec.kind == K_ADDR
      |=> pready && prdata == mem_base_q[$past(dec.chan)])
      else $error("memory base read lost bits");

   a_locked_write: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      seq_setup_wr_addr ##0 cfg_q[dec.chan].enable |=> seq_access_refused ##1 $stable(mem_base_q))
      else $error("memory base changed while channel enabled");

   a_open_write: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      seq_setup_wr_addr ##0 !cfg_q[dec.chan].enable |=> pready && !pslverr)
      else $error("write to disabled channel refused");

   a_eff_tracks: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      cfg_q[0].memory_transfer_width == WIDTH_32 && $stable(cfg_q[0]) ##1 $stable(mem_base_q[0])
      |-> chan_mem_addr[0][1:0] == 2'h0)
      else $error("channel one not word aligned");

   a_answer_once: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      pready |=> !pready)
      else $error("pready held beyond one access cycle");

   a_reset_holds_base: assert property (
      @(posedge clk)
      !rst_s_n |-> (mem_base_q == '0) && (chan_mem_addr == '0))
      else $error("memory base not held at zero in reset");

   a_reset_bus_quiet: assert property (
      @(posedge clk)
      !rst_s_n |-> !pready && !pslverr && (prdata == '0))
      else $error("bus outputs active in reset");

   a_base_only_on_commit: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      !(commit && dec.kind == K_ADDR) |=> $stable(mem_base_q))
      else $error("memory base changed without a write");

   a_eff_write_refused: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      seq_setup_wr_eff |=> pready && pslverr)
      else $error("write to effective address accepted");

   a_unmapped_refused: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      setup && (state_q == ST_IDLE) && (dec.kind == K_NONE) |=> pready && pslverr)
      else $error("unmapped address accepted");

   a_mapped_read_ok: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      setup && !pwrite && (state_q == ST_IDLE) && (dec.kind != K_NONE) |=> pready && !pslverr)
      else $error("read of mapped register refused");

   a_cfg_write_kept: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      commit && dec.kind == K_CFG && pstrb[1]
      |=> cfg_q[$past(dec.chan)].memory_transfer_width == $past(pwdata[`WIDTH_MSB:`WIDTH_LSB]))
      else $error("memory width field write not stored");

endmodule

// ==== testbench/dma_channel_memory_address_tb.sv ====
// Self-checking testbench of the per-channel memory base address block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "dma_cma_cfg.svh"

module dma_channel_memory_address_tb
   import dma_cma_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`PADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   chan_cfg_s [`NUM_CHAN-1:0] chan_cfg;
   addr_t [`NUM_CHAN-1:0] chan_mem_addr;
   int n_errors = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic err;

   always #2 clk = ~clk;

   dma_channel_memory_address uut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .chan_cfg(chan_cfg), .chan_mem_addr(chan_mem_addr)
   );

   // ---------------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // ---------------------------------------------------------------------
   // APB master
   // ---------------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         $display("wrong value pready expected 1 seen 0");
         tally_and_finish();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   function automatic logic [11:0] base_of(input int n);
      return 12'(`CMA_BASE + 20 * n);
   endfunction

   function automatic logic [11:0] cfg_of(input int n);
      return 12'(`CFG_BASE + 20 * n);
   endfunction

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_reset();
      for (int n = 0; n < 8; n++) begin
         apb(1'b0, base_of(n), '0, 4'h0);
         check("base after reset", rd, 32'h0000_0000);
         check("aligned after reset", chan_mem_addr[n], 32'h0000_0000);
      end
      $display("Test reset values done");
   endtask

   task automatic t_map();
      for (int n = 0; n < 8; n++) begin
         apb(1'b1, base_of(n), 32'h0F0F_0F03 + 32'(n) * 32'h1010_1010, 4'hF);
         check("write error", {31'h0, err}, 32'h0);
      end
      for (int n = 0; n < 8; n++) begin
         apb(1'b0, base_of(n), '0, 4'h0);
         check("base readback", rd, 32'h0F0F_0F03 + 32'(n) * 32'h1010_1010);
      end
      apb(1'b1, base_of(0), 32'hFFFF_FFFF, 4'h2);
      apb(1'b0, base_of(0), '0, 4'h0);
      check("byte lane write", rd, 32'h0F0F_FF03);
      apb(1'b0, 12'h004, '0, 4'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, 12'(`EFF_BASE), 32'h0000_0001, 4'hF);
      check("read-only write error", {31'h0, err}, 32'h1);
      $display("Test register map done");
   endtask

   task automatic t_align();
      logic [31:0] mask [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFC, 32'hFFFF_FFFF};
      apb(1'b1, base_of(2), 32'hDEAD_BEE7, 4'hF);
      for (int w = 0; w < 4; w++) begin
         apb(1'b1, cfg_of(0), 32'(w) << `WIDTH_LSB, 4'hF);
         apb(1'b1, cfg_of(2), 32'(w) << `WIDTH_LSB, 4'hF);
         repeat (3) @(posedge clk);
         check("width field", 32'(chan_cfg[2].memory_transfer_width), 32'(w));
         check("aligned output", chan_mem_addr[2], 32'hDEAD_BEE7 & mask[w]);
         check("aligned channel one", chan_mem_addr[0], 32'h0F0F_FF03 & mask[w]);
         apb(1'b0, cfg_of(2), '0, 4'h0);
         check("config readback", rd, 32'(w) << `WIDTH_LSB);
         apb(1'b0, 12'(`EFF_BASE + 8), '0, 4'h0);
         check("effective register", rd, 32'hDEAD_BEE7 & mask[w]);
         apb(1'b0, base_of(2), '0, 4'h0);
         check("full base kept", rd, 32'hDEAD_BEE7);
      end
      $display("Test alignment done");
   endtask

   task automatic t_enabled();
      apb(1'b1, base_of(4), 32'h2000_1000, 4'hF);
      apb(1'b1, cfg_of(4), 32'h0000_0001, 4'hF);
      @(posedge clk);
      check("enable bit", {31'h0, chan_cfg[4].enable}, 32'h1);
      apb(1'b1, base_of(4), 32'h3000_2000, 4'hF);
      check("busy write error", {31'h0, err}, 32'h1);
      apb(1'b0, base_of(4), '0, 4'h0);
      check("base kept while enabled", rd, 32'h2000_1000);
      apb(1'b1, cfg_of(4), 32'h0000_0000, 4'hF);
      apb(1'b1, base_of(4), 32'h3000_2000, 4'hF);
      check("idle write error", {31'h0, err}, 32'h0);
      apb(1'b0, base_of(4), '0, 4'h0);
      check("base after idle write", rd, 32'h3000_2000);
      $display("Test write while enabled done");
   endtask

   task automatic t_reset_again();
      apb(1'b1, base_of(1), 32'h1234_5678, 4'hF);
      apb(1'b1, cfg_of(1), 32'h0000_0801, 4'hF);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, base_of(1), '0, 4'h0);
      check("base after second reset", rd, 32'h0000_0000);
      check("aligned after second reset", chan_mem_addr[1], 32'h0000_0000);
      check("config after second reset", 32'(chan_cfg[1]), 32'h0000_0000);
      $display("Test reset in mid-run done");
   endtask

   // ---------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_map();
      t_align();
      t_enabled();
      t_reset_again();
      tally_and_finish();
   end
endmodule
